/* verilog/pixel_thread_payload_builder.v */
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "payload_map.vh"

module pixel_thread_payload_builder #(
  parameter CNT_W = 24
) (
  input wire pclk, // APB and pipeline clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire disp_valid, // Dispatch request valid
  output wire disp_ready, // Builder can take a dispatch
  input wire [4:0] disp_topology, // Primitive topology type
  input wire [23:0] disp_prim_tid, // Primitive thread count
  input wire [7:0] disp_tag, // Fused thread tag
  input wire [15:0] disp_lit_mask, // Lit pixel/sample mask
  input wire [1:0] disp_surf_kind, // Render target surface kind
  input wire [3:0] disp_vp0, // Lower-half viewport index
  input wire [10:0] disp_rtai0, // Lower-half array index
  input wire disp_face0, // Lower-half back facing
  input wire [1:0] disp_sspi0, // Lower-half sample pair index
  input wire [3:0] disp_vp1, // Upper-half viewport index
  input wire [10:0] disp_rtai1, // Upper-half array index
  input wire disp_face1, // Upper-half back facing
  input wire [1:0] disp_sspi1, // Upper-half sample pair index
  input wire [127:0] disp_coords, // Subspan 0..3 {Y,X} words
  input wire [127:0] disp_coords_hi, // Subspan 4..7 {Y,X} words
  output reg [15:0] dispatch_mask, // Thread dispatch mask
  output wire [2:0] ext_sel, // Portion whose external word is wanted
  output wire [6:0] ext_index, // {register, word} within that portion
  input wire [31:0] ext_data, // External constant/setup word
  output wire pl_valid, // Payload word valid
  input wire pl_ready, // Consumer takes payload word
  output reg [31:0] pl_data, // Payload word
  output reg [7:0] pl_reg, // Payload register number
  output reg [2:0] pl_word, // Word within register
  output reg pl_last // Last word of payload
);

  localparam ST_IDLE = 3'b001;
  localparam ST_LOAD = 3'b010;
  localparam ST_EMIT = 3'b100;

  reg [2:0] state;
  reg [31:0] ctrl;
  reg [31:0] sampler_ptr;
  reg [31:0] binding_ptr;
  reg [31:0] blend_ptr;
  reg [21:0] scratch_idx;
  reg [CNT_W-1:0] fused_count;
  reg [31:0] snap_ctrl;
  reg [4:0] l_topology;
  reg [23:0] l_prim_tid;
  reg [7:0] l_tag;
  reg [CNT_W-1:0] l_count;
  reg [15:0] l_lit;
  reg [31:0] l_half0;
  reg [31:0] l_half1;
  reg [127:0] l_coords;
  reg [127:0] l_coords_hi;
  reg [2:0] portion;
  reg [3:0] sub;
  reg [2:0] word;
  reg [7:0] reg_num;
  reg [2:0] next_portion;
  reg [3:0] next_sub;
  reg [2:0] next_word;
  reg [7:0] next_reg_num;
  reg [31:0] next_data;
  reg [2:0] ld_portion;
  reg [3:0] ld_sub;
  reg [2:0] ld_word;
  reg mapped;
  reg [31:0] rd_mux;

  // Length in registers of a portion; zero means the portion is absent
  function [3:0] portion_len;
    input [2:0] p;
    input [31:0] c;
    begin
      case (p)
        `PORT_HEADER: portion_len = 4'h1;
        `PORT_MASKS: portion_len = 4'h1;
        `PORT_UPPER: portion_len = {3'h0, c[`CTRL_UPPER_COORD_BIT]};
        `PORT_CONST: portion_len = c[`CTRL_CONST_LEN_LSB +: 4];
        `PORT_SETUP: portion_len = c[`CTRL_SETUP_LEN_LSB +: 4];
        default: portion_len = 4'h0;
      endcase
    end
  endfunction

  // First enabled portion after p
  function [2:0] following;
    input [2:0] p;
    input [31:0] c;
    begin
      // Masks always follow the header, before any optional portion
      if (p < `PORT_MASKS)
        following = `PORT_MASKS;
      else if (p < `PORT_UPPER && portion_len(`PORT_UPPER, c) != 4'h0)
        following = `PORT_UPPER;
      else if (p < `PORT_CONST && portion_len(`PORT_CONST, c) != 4'h0)
        following = `PORT_CONST;
      else if (p < `PORT_SETUP && portion_len(`PORT_SETUP, c) != 4'h0)
        following = `PORT_SETUP;
      else
        following = `PORT_DONE;
    end
  endfunction

  // Per-half word: viewport, array index or face, facing, sample pair
  function [31:0] half_word;
    input [3:0] vp;
    input [10:0] rtai;
    input face;
    input [1:0] sspi;
    input [1:0] kind;
    reg [10:0] idx;
    begin
      idx = rtai;
      if (kind == `SURF_SIX_FACE && rtai > `CUBE_FACE_MAX)
        idx = `CUBE_FACE_MAX;
      half_word = 32'h0000_0000;
      half_word[`HALF_VP_LSB +: 4] = vp;
      half_word[`HALF_RTAI_LSB +: 11] = idx;
      half_word[`HALF_FACE_BIT] = face;
      half_word[`HALF_SSPI_LSB +: 2] = sspi;
    end
  endfunction

  // Whole subspan goes active if any of its pixels is lit
  function [15:0] widen_mask;
    input [15:0] lit;
    integer i;
    begin
      widen_mask = 16'h0000;
      for (i = 0; i < 4; i = i + 1)
        widen_mask[4*i +: 4] = {4{|lit[4*i +: 4]}};
    end
  endfunction

  // APB: zero wait states; read data is latched in the setup cycle, writes land in the access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @*
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: rd_mux = ctrl;
      `OFS_SAMPLER_PTR: rd_mux = sampler_ptr;
      `OFS_BINDING_PTR: rd_mux = binding_ptr;
      `OFS_BLEND_PTR: rd_mux = blend_ptr;
      `OFS_SCRATCH_IDX: rd_mux = {scratch_idx, 10'h000};
      `OFS_STATUS:
      begin
        rd_mux[23:0] = fused_count[23:0];
        rd_mux[`STAT_BUSY_BIT] = ~state[0];
      end
      default: mapped = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      ctrl <= `RST_CTRL;
      sampler_ptr <= `RST_PTR;
      binding_ptr <= `RST_PTR;
      blend_ptr <= `RST_PTR;
      scratch_idx <= 22'h000000;
    end
    else
    begin
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
      if (psel && penable && pwrite)
      begin
        case (paddr)
          `OFS_CTRL: ctrl <= pwdata;
          `OFS_SAMPLER_PTR: sampler_ptr <= {pwdata[31:5], 5'h00};
          `OFS_BINDING_PTR: binding_ptr <= {pwdata[31:5], 5'h00};
          `OFS_BLEND_PTR: blend_ptr <= {pwdata[31:6], 6'h00};
          `OFS_SCRATCH_IDX: scratch_idx <= pwdata[31:10];
          default: ;
        endcase
      end
    end
  end

  // Position walk: words 0..7, registers, then the next enabled portion
  always @*
  begin
    next_portion = portion;
    next_sub = sub;
    next_word = word + 3'h1;
    next_reg_num = reg_num;
    if (word == 3'h7)
    begin
      next_word = 3'h0;
      next_reg_num = reg_num + 8'h01;
      if (sub + 4'h1 < portion_len(portion, snap_ctrl))
        next_sub = sub + 4'h1;
      else
      begin
        next_sub = 4'h0;
        next_portion = following(portion, snap_ctrl);
        if (next_portion == `PORT_CONST)
          next_reg_num = reg_num + 8'h01 + {4'h0, snap_ctrl[`CTRL_CONST_GAP_LSB +: 4]};
        else if (next_portion == `PORT_SETUP)
          next_reg_num = reg_num + 8'h01 + {4'h0, snap_ctrl[`CTRL_SETUP_GAP_LSB +: 4]};
      end
    end
  end

  always @*
  begin
    if (state == ST_LOAD)
    begin
      ld_portion = portion;
      ld_sub = sub;
      ld_word = word;
    end
    else
    begin
      ld_portion = next_portion;
      ld_sub = next_sub;
      ld_word = next_word;
    end
  end

  assign ext_sel = ld_portion;
  assign ext_index = {ld_sub, ld_word};

  // Word contents at the position being loaded
  always @*
  begin
    next_data = 32'h0000_0000;
    case (ld_portion)
      `PORT_HEADER:
      begin
        case (ld_word)
          3'h0:
          begin
            next_data[`W0_SRC_DEPTH_BIT] = snap_ctrl[`CTRL_SRC_DEPTH_RT_BIT];
            next_data[`W0_COVERAGE_BIT] = snap_ctrl[`CTRL_COVERAGE_RT_BIT];
            next_data[4:0] = l_topology;
          end
          3'h1: next_data = blend_ptr;
          3'h2: next_data = 32'h0000_0000;
          3'h3: next_data = sampler_ptr;
          3'h4: next_data = binding_ptr;
          3'h5: next_data = {scratch_idx, 2'h0, l_tag};
          3'h6: next_data[23:0] = l_count[23:0];
          default: next_data[23:0] = l_prim_tid;
        endcase
      end
      `PORT_MASKS:
      begin
        case (ld_word)
          3'h0: next_data = 32'h0000_0000;
          3'h1: next_data = l_half0;
          3'h6: next_data = l_half1;
          3'h7: next_data = {l_lit, l_lit};
          default: next_data = l_coords[32*(ld_word-3'h2) +: 32];
        endcase
      end
      `PORT_UPPER:
      begin
        if (ld_word >= 3'h2 && ld_word <= 3'h5)
          next_data = l_coords_hi[32*(ld_word-3'h2) +: 32];
      end
      `PORT_CONST, `PORT_SETUP: next_data = ext_data;
      default: next_data = 32'h0000_0000;
    endcase
  end

  assign disp_ready = state[0];
  assign pl_valid = state[2];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      fused_count <= {CNT_W{1'b0}};
      snap_ctrl <= `RST_CTRL;
      l_topology <= 5'h00;
      l_prim_tid <= 24'h000000;
      l_tag <= 8'h00;
      l_count <= {CNT_W{1'b0}};
      l_lit <= 16'h0000;
      l_half0 <= 32'h0000_0000;
      l_half1 <= 32'h0000_0000;
      l_coords <= {128{1'b0}};
      l_coords_hi <= {128{1'b0}};
      dispatch_mask <= 16'h0000;
      portion <= `PORT_HEADER;
      sub <= 4'h0;
      word <= 3'h0;
      reg_num <= 8'h00;
      pl_data <= 32'h0000_0000;
      pl_reg <= 8'h00;
      pl_word <= 3'h0;
      pl_last <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (disp_valid)
          begin
            // Control snapshot keeps the payload layout fixed; pointer and scratch words are read live
            snap_ctrl <= ctrl;
            l_topology <= disp_topology;
            l_prim_tid <= disp_prim_tid;
            l_tag <= disp_tag;
            l_count <= fused_count + {{(CNT_W-1){1'b0}}, 1'b1};
            fused_count <= fused_count + {{(CNT_W-1){1'b0}}, 1'b1};
            l_lit <= disp_lit_mask;
            dispatch_mask <= widen_mask(disp_lit_mask);
            l_half0 <= half_word(disp_vp0, disp_rtai0, disp_face0, disp_sspi0,
              disp_surf_kind);
            l_half1 <= half_word(disp_vp1, disp_rtai1, disp_face1, disp_sspi1,
              disp_surf_kind);
            l_coords <= disp_coords;
            l_coords_hi <= disp_coords_hi;
            portion <= `PORT_HEADER;
            sub <= 4'h0;
            word <= 3'h0;
            reg_num <= 8'h00;
            state <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          pl_data <= next_data;
          pl_reg <= reg_num;
          pl_word <= word;
          pl_last <= 1'b0;
          state <= ST_EMIT;
        end
        ST_EMIT:
        begin
          if (pl_ready)
          begin
            if (pl_last)
              state <= ST_IDLE;
            else
            begin
              portion <= next_portion;
              sub <= next_sub;
              word <= next_word;
              reg_num <= next_reg_num;
              pl_data <= next_data;
              pl_reg <= next_reg_num;
              pl_word <= next_word;
              // Last word when the walk after this one runs out
              pl_last <= (next_word == 3'h7) &&
                (next_sub + 4'h1 >= portion_len(next_portion, snap_ctrl)) &&
                (following(next_portion, snap_ctrl) == `PORT_DONE);
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

/* verilog/payload_map.vh */
`ifndef PAYLOAD_MAP_VH
`define PAYLOAD_MAP_VH

// APB register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SAMPLER_PTR 8'h04
`define OFS_BINDING_PTR 8'h08
`define OFS_BLEND_PTR 8'h0C
`define OFS_SCRATCH_IDX 8'h10
`define OFS_STATUS 8'h14

// Reset values
`define RST_CTRL 32'h0000_0000
`define RST_PTR 32'h0000_0000

// Control register fields
`define CTRL_UPPER_COORD_BIT 2
`define CTRL_COVERAGE_RT_BIT 12
`define CTRL_SRC_DEPTH_RT_BIT 13
`define CTRL_CONST_LEN_LSB 16
`define CTRL_CONST_GAP_LSB 20
`define CTRL_SETUP_LEN_LSB 24
`define CTRL_SETUP_GAP_LSB 28

// Status register fields
`define STAT_BUSY_BIT 31

// Payload word fields
`define W0_SRC_DEPTH_BIT 13
`define W0_COVERAGE_BIT 12
`define W5_SCRATCH_LSB 10
`define HALF_VP_LSB 27
`define HALF_RTAI_LSB 16
`define HALF_FACE_BIT 15
`define HALF_SSPI_LSB 6
`define CUBE_FACE_MAX 11'h005

// Payload portions in emission order
`define PORT_HEADER 3'h0
`define PORT_MASKS 3'h1
`define PORT_UPPER 3'h2
`define PORT_CONST 3'h3
`define PORT_SETUP 3'h4
`define PORT_DONE 3'h5

// Surface kinds
`define SURF_LINEAR 2'h0
`define SURF_PLANAR 2'h1
`define SURF_VOLUME 2'h2
`define SURF_SIX_FACE 2'h3

`endif

/* verification/payload_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module payload_chk (
  input wire pclk, // Clock
  input wire presetn, // Reset, active low
  input wire psel, // Select
  input wire penable, // Access phase
  input wire [7:0] paddr, // Address
  input wire pslverr, // Error
  input wire disp_valid, // Request
  input wire disp_ready, // Idle
  input wire [15:0] dispatch_mask, // Widened mask
  input wire pl_valid, // Word valid
  input wire pl_ready, // Word taken
  input wire [31:0] pl_data, // Word
  input wire [7:0] pl_reg, // Register
  input wire [2:0] pl_word, // Word index
  input wire pl_last // Last word
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence take_s;
    disp_valid && disp_ready;
  endsequence
  sequence emit_s;
    !disp_ready && !pl_valid ##1 pl_valid && pl_reg == 8'h00 && pl_word == 3'h0;
  endsequence
  chk_first_word: assert property (take_s |=> emit_s)
    else $error("payload start wrong");
  chk_busy_refuse: assert property (pl_valid |-> !disp_ready)
    else $error("ready while emitting");
  chk_word_hold: assert property (pl_valid && !pl_ready |=> pl_valid && $stable(pl_data))
    else $error("word not held");
  chk_word_step: assert property (pl_valid && pl_ready && !pl_last |=>
    pl_valid && pl_word == $past(pl_word) + 3'h1)
    else $error("word order broken");
  chk_last_idle: assert property (pl_valid && pl_ready && pl_last |=> disp_ready && !pl_valid)
    else $error("no idle after last");
  chk_zero_word: assert property (pl_valid && pl_reg == 8'h00 && pl_word == 3'h2 |->
    pl_data == 32'h0)
    else $error("word two not zero");
  chk_mask_copy: assert property (pl_valid && pl_reg == 8'h01 && pl_word == 3'h7 |->
    pl_data[31:16] == pl_data[15:0])
    else $error("mask copy differs");
  chk_widen_mask: assert property (pl_valid |->
    ((dispatch_mask ^ {dispatch_mask[14:0], 1'b0}) & 16'hEEEE) == 16'h0)
    else $error("subspan not whole");
  chk_err_unmapped: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > 8'h14))
    else $error("error flag wrong");
endmodule
`default_nettype wire

/* verification/payload_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module payload_sink (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic slow, // Stall every other cycle
  input wire logic pl_valid, // Word valid
  input wire logic [31:0] pl_data, // Word
  input wire logic [7:0] pl_reg, // Register
  output logic pl_ready, // Word taken
  output int n // Words captured
);
  logic [31:0] d [0:255];
  logic [7:0] r [0:255];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      n <= 0;
      pl_ready <= 1'b0;
    end
    else
    begin
      pl_ready <= slow ? !pl_ready : 1'b1;
      if (pl_valid && pl_ready)
      begin
        // Kernel never edits the lit field, so both halves are stored as sent
        d[n] <= pl_data;
        r[n] <= pl_reg;
        n <= n + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/test_pixel_thread_payload_builder.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pixel_thread_payload_builder;
  typedef struct {logic [4:0] topo; logic [15:0] lit, dm; logic [1:0] kind; logic [10:0] ra, era;} row_t;
  row_t rows[4] = '{'{5'h01, 16'h0102, 16'h0F0F, 2'h0, 11'h7FF, 11'h7FF},
    '{5'h1F, 16'h8000, 16'hF000, 2'h1, 11'h400, 11'h400},
    '{5'h04, 16'hFFFF, 16'hFFFF, 2'h2, 11'h123, 11'h123},
    '{5'h0A, 16'h0010, 16'h00F0, 2'h3, 11'h009, 11'h005}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, disp_valid = 0, slow = 0;
  logic disp_face0 = 0, disp_face1 = 0, err;
  logic [7:0] paddr = 0, disp_tag = 0;
  logic [31:0] pwdata = 0, rd, ctl;
  logic [4:0] disp_topology = 0;
  logic [23:0] disp_prim_tid = 0;
  logic [15:0] disp_lit_mask = 0;
  logic [1:0] disp_surf_kind = 0, disp_sspi0 = 0, disp_sspi1 = 0;
  logic [3:0] disp_vp0 = 0, disp_vp1 = 0;
  logic [10:0] disp_rtai0 = 0, disp_rtai1 = 0, era;
  logic [127:0] disp_coords = 128'h0040_0080_0030_0060_0020_0040_0010_0020;
  logic [127:0] disp_coords_hi = 128'h0F40_0F80_0F30_0F60_0F20_0F40_0F10_0F20;
  wire [31:0] prdata, ext_data, pl_data;
  wire pready, pslverr, disp_ready, pl_valid, pl_ready, pl_last;
  wire [15:0] dispatch_mask;
  wire [2:0] ext_sel, pl_word;
  wire [6:0] ext_index;
  wire [7:0] pl_reg;
  int n, base, mismatches = 0, total_checks = 0, cnt = 0;
  assign ext_data = {ext_sel, 22'h0, ext_index};
  pixel_thread_payload_builder pixel_thread_payload_builder_inst (.*);
  payload_sink payload_sink_inst (.*);
  initial
    forever #20 pclk = ~pclk;
  task automatic complete_run(input bit hung);
    if (hung)
      mismatches++;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input w, input [7:0] a, input [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 50)
      complete_run(1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dispatch(input int words);
    int k;
    base = n;
    disp_valid <= 1'b1;
    for (k = 0; k < 300 && disp_ready !== 1'b1; k++)
      @(negedge pclk);
    if (k == 300)
      complete_run(1);
    @(posedge pclk);
    disp_valid <= 1'b0;
    cnt++;
    for (k = 0; k < 300 && n < base + words; k++)
      @(negedge pclk);
    if (k == 300)
      complete_run(1);
  endtask
  function automatic [31:0] half(input [3:0] v, input f, input [1:0] s);
    half = {1'b0, v, era, f, 7'h0, s, 6'h0};
  endfunction
  function automatic [31:0] expw(input int i);
    case (i)
      0: expw = {18'h0, ctl[13:12], 7'h0, disp_topology};
      1: expw = 32'hFFFF_FFC0;
      3: expw = 32'hFFFF_FFE0;
      4: expw = 32'h1234_5660;
      5: expw = {22'h3F_FFFF, 2'h0, disp_tag};
      6: expw = {8'h0, cnt[23:0]};
      7: expw = {8'h0, disp_prim_tid};
      9: expw = half(disp_vp0, disp_face0, disp_sspi0);
      10, 11, 12, 13: expw = disp_coords[32 * (i - 10) +: 32];
      14: expw = half(disp_vp1, disp_face1, disp_sspi1);
      15: expw = {disp_lit_mask, disp_lit_mask};
      18, 19, 20, 21: expw = disp_coords_hi[32 * (i - 18) +: 32];
      default: expw = 32'h0;
    endcase
  endfunction
  task automatic check_words(input int words);
    for (int j = 0; j < words; j++)
    begin
      check(payload_sink_inst.d[base + j], expw(j));
      check(payload_sink_inst.r[base + j], j < 24 ? j / 8 : j < 32 ? 5 : 6);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0);
    check(rd, 32'h0);
    apb(1, 8'h04, 32'hFFFF_FFFF);
    apb(1, 8'h08, 32'h1234_567F);
    apb(1, 8'h0C, 32'hFFFF_FFFF);
    apb(1, 8'h10, 32'hFFFF_FFFF);
    apb(0, 8'h04, 0);
    check(rd, 32'hFFFF_FFE0);
    apb(0, 8'h18, 0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("test registers done");
    foreach (rows[i])
    begin
      ctl = {18'h0, i[1:0], 12'h0};
      apb(1, 8'h00, ctl);
      disp_topology <= rows[i].topo;
      disp_lit_mask <= rows[i].lit;
      disp_surf_kind <= rows[i].kind;
      disp_rtai0 <= rows[i].ra;
      disp_rtai1 <= rows[i].ra;
      era = rows[i].era;
      disp_vp0 <= i[3:0];
      disp_vp1 <= 4'hF - i[3:0];
      disp_face0 <= !i[0];
      disp_face1 <= i[0];
      disp_sspi0 <= i[1:0];
      disp_sspi1 <= ~i[1:0];
      disp_tag <= 8'hF0 + i[7:0];
      disp_prim_tid <= 24'hFF_FFFF - i[23:0];
      slow <= i[0];
      dispatch(16);
      check(dispatch_mask, rows[i].dm);
      check_words(16);
      $display("test row %0d done", i);
    end
    // Upper coordinates, const after a gap of two, setup with none, consumer stalling
    ctl = 32'h0121_3004;
    apb(1, 8'h00, ctl);
    slow <= 1'b1;
    dispatch(40);
    check_words(24);
    for (int j = 0; j < 16; j++)
      check(payload_sink_inst.d[base + 24 + j], {j < 8 ? 3'h3 : 3'h4, 22'h0, 4'h0, j[2:0]});
    check(payload_sink_inst.r[base + 24], 32'h5);
    check(payload_sink_inst.r[base + 32], 32'h6);
    apb(0, 8'h14, 0);
    check(rd, {8'h0, cnt[23:0]});
    $display("test optional portions done");
    // Reset after the last payload is taken leaves the builder idle with counters cleared
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({31'h0, pl_valid}, 32'h0);
    check({31'h0, disp_ready}, 32'h1);
    check(dispatch_mask, 32'h0);
    presetn <= 1'b1;
    apb(0, 8'h14, 0);
    check(rd, 32'h0);
    apb(0, 8'h00, 0);
    check(rd, 32'h0);
    $display("test reset done");
    complete_run(0);
  end
endmodule
bind pixel_thread_payload_builder payload_chk payload_chk_inst (.*);
`default_nettype wire
